// File: psa_pkg.sv
/*
 * psa_pkg: constants and carrier types for the program space access unit.
 * assumes a 16-bit data-side core and a 24-bit program memory array.
 */
package psa_pkg;

  // ********************************************************************
  // widths and bit positions
  // ********************************************************************
  localparam int PAGE_W    = 8;
  localparam int EA_W      = 16;
  localparam int PADDR_W   = 24;
  localparam int PWORD_W   = 24;
  localparam int DATA_W    = 32;
  localparam int SPACE_BIT = 7;   // table page bit picking config space
  localparam int EA_TOP    = 15;
  localparam int VIS_EN_BIT = 2;  // visibility enable in core control

  // ********************************************************************
  // register map (byte addresses)
  // ********************************************************************
  localparam logic [7:0] OFF_TABLE_PAGE   = 8'h00;
  localparam logic [7:0] OFF_VIS_PAGE     = 8'h04;
  localparam logic [7:0] OFF_CORE_CONTROL = 8'h08;
  localparam logic [7:0] OFF_STATUS       = 8'h0C;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [7:0]  RST_PAGE = 8'h00;
  localparam logic [15:0] RST_CORE = 16'h0000;

  // ********************************************************************
  // extra cycle counts for remap-window use
  // ********************************************************************
  localparam logic [1:0] EXTRA_MOVE  = 2'h1;
  localparam logic [1:0] EXTRA_OTHER = 2'h2;
  localparam logic [1:0] EXTRA_NONE  = 2'h0;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_TABLE_READ_LOW,
    OP_TABLE_READ_HIGH,
    OP_TABLE_WRITE_LOW,
    OP_TABLE_WRITE_HIGH,
    OP_DATA_READ
  } psa_op_e;

  // request from the core execution unit
  typedef struct packed {
    logic                  valid;
    psa_op_e               op;
    logic                  byteMode;
    logic [EA_W-1:0]       effectiveAddr;
    logic [15:0]           wdata;
    logic                  isMove;      // move or double move
    logic                  inRepeat;
    logic                  repFirst;
    logic                  repLast;
    logic                  repIntExit;
    logic                  repIntEntry;
  } psa_req_s;

  // answer towards the core
  typedef struct packed {
    logic                  done;
    logic [15:0]           rdata;
    logic                  refused;
    logic                  redirected;
    logic [1:0]            extraCycles;
  } psa_rsp_s;

  // flash array side
  typedef struct packed {
    logic                  rd;
    logic                  wr;
    logic                  wrHigh;
    logic                  cfgSpace;
    logic [PADDR_W-1:0]    addr;
    logic [15:0]           wdata;
  } psa_mem_s;

endpackage

// File: psa_access_unit.sv
/*
 * psa_access_unit: table operations and remap window into program space,
 * with an AXI4-Lite slave holding the page and core control registers.
 * assumes the flash array drives memRdata while rd is high and holds it one clock after,
 * and that the core holds its request until done.
 */
`timescale 1ns/1ps
module psa_access_unit (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // core execution unit
  input  wire psa_pkg::psa_req_s    coreReq,
  output psa_pkg::psa_rsp_s         coreRsp,
  // program flash array
  output psa_pkg::psa_mem_s         memReq,
  input  wire logic [23:0]          memRdata
);

  // ********************************************************************
  // reset release
  // ********************************************************************
  logic rstSync1_reg;
  logic rstSync2_reg;
  logic rstN;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end
  assign rstN = rstSync2_reg;

  // ********************************************************************
  // register bus
  // ********************************************************************
  logic [7:0]  tablePage_reg, tablePage_next;
  logic [7:0]  visPage_reg, visPage_next;
  logic [15:0] coreControl_reg, coreControl_next;
  logic [7:0]  awAddr_reg, awAddr_next;
  logic        awHeld_reg, awHeld_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0]  wStrb_reg, wStrb_next;
  logic        wHeld_reg, wHeld_next;
  logic        bValid_reg, bValid_next;
  logic [1:0]  bResp_reg, bResp_next;
  logic        rValid_reg, rValid_next;
  logic [31:0] rData_reg, rData_next;
  logic [1:0]  rResp_reg, rResp_next;
  logic        refusedSticky_reg, refusedSticky_next;
  logic        busy_reg;
  psa_pkg::psa_rsp_s coreRsp_reg, coreRsp_next;
  logic        doWrite;
  logic        visEnable;

  assign visEnable = coreControl_reg[psa_pkg::VIS_EN_BIT];
  assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;

  always_comb begin
    awAddr_next      = awAddr_reg;
    awHeld_next      = awHeld_reg;
    wData_next       = wData_reg;
    wStrb_next       = wStrb_reg;
    wHeld_next       = wHeld_reg;
    bValid_next      = bValid_reg;
    bResp_next       = bResp_reg;
    rValid_next      = rValid_reg;
    rData_next       = rData_reg;
    rResp_next       = rResp_reg;
    tablePage_next   = tablePage_reg;
    visPage_next     = visPage_reg;
    coreControl_next = coreControl_reg;
    refusedSticky_next = refusedSticky_reg;
    if (s_axi_awvalid && !awHeld_reg) begin
      awAddr_next = s_axi_awaddr;
      awHeld_next = 1'b1;
    end
    if (s_axi_wvalid && !wHeld_reg) begin
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
      wHeld_next = 1'b1;
    end
    if (doWrite) begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bValid_next = 1'b1;
      bResp_next  = psa_pkg::AXI_OKAY;
      case (awAddr_reg)
        psa_pkg::OFF_TABLE_PAGE: begin
          if (wStrb_reg[0]) tablePage_next = wData_reg[7:0];
        end
        psa_pkg::OFF_VIS_PAGE: begin
          if (wStrb_reg[0]) visPage_next = wData_reg[7:0];
        end
        psa_pkg::OFF_CORE_CONTROL: begin
          if (wStrb_reg[0]) coreControl_next[7:0] = wData_reg[7:0];
          if (wStrb_reg[1]) coreControl_next[15:8] = wData_reg[15:8];
        end
        // writing bit 0 clears the refused flag
        psa_pkg::OFF_STATUS: begin
          if (wStrb_reg[0] && wData_reg[0]) refusedSticky_next = 1'b0;
        end
        default: bResp_next = psa_pkg::AXI_SLVERR;
      endcase
    end else if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
    // a new refusal wins over a clear in the same cycle
    if (coreRsp_next.refused) refusedSticky_next = 1'b1;
    if (s_axi_arvalid && !rValid_reg) begin
      rValid_next = 1'b1;
      rResp_next  = psa_pkg::AXI_OKAY;
      case (s_axi_araddr)
        psa_pkg::OFF_TABLE_PAGE:   rData_next = {24'h000000, tablePage_reg};
        psa_pkg::OFF_VIS_PAGE:     rData_next = {24'h000000, visPage_reg};
        psa_pkg::OFF_CORE_CONTROL: rData_next = {16'h0000, coreControl_reg};
        psa_pkg::OFF_STATUS:
          rData_next = {29'h00000000, busy_reg, refusedSticky_reg, visEnable};
        default: begin
          rData_next = 32'h00000000;
          rResp_next = psa_pkg::AXI_SLVERR;
        end
      endcase
    end else if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
    end
  end

  // ********************************************************************
  // access sequencer
  // ********************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH1, ST_FETCH2} psa_state_e;

  psa_state_e         state_reg, state_next;
  psa_pkg::psa_mem_s  memReq_reg, memReq_next;
  psa_pkg::psa_op_e   op_reg, op_next;
  logic               byteSel_reg, byteSel_next;
  logic               byteMode_reg, byteMode_next;
  logic               reqLive;
  logic               tableOp;
  logic               isWrite;
  logic               redirect;
  logic [23:0]        tableAddr;
  logic [23:0]        remapAddr;
  logic [15:0]        lowData;
  logic [15:0]        highData;

  // byte select when byte mode, else the whole field
  function automatic logic [15:0] pick(input logic [15:0] word,
                                       input logic        bMode,
                                       input logic        bSel);
    if (!bMode) pick = word;
    else if (bSel) pick = {8'h00, word[15:8]};
    else pick = {8'h00, word[7:0]};
  endfunction

  assign tableOp = coreReq.op inside {psa_pkg::OP_TABLE_READ_LOW,
                                      psa_pkg::OP_TABLE_READ_HIGH,
                                      psa_pkg::OP_TABLE_WRITE_LOW,
                                      psa_pkg::OP_TABLE_WRITE_HIGH};
  assign isWrite = coreReq.op inside {psa_pkg::OP_TABLE_WRITE_LOW,
                                      psa_pkg::OP_TABLE_WRITE_HIGH};
  // the core still holds the old request at the edge that shows done
  assign reqLive = coreReq.valid && !coreRsp_reg.done;
  // unaligned addresses pass unchanged; word index is address bits 23..1
  assign tableAddr = {tablePage_reg, coreReq.effectiveAddr};
  assign remapAddr = {1'b0, visPage_reg,
                      coreReq.effectiveAddr[14:0]};
  assign redirect  = coreReq.op == psa_pkg::OP_DATA_READ &&
                     coreReq.effectiveAddr[psa_pkg::EA_TOP] && visEnable;
  assign lowData   = pick(memRdata[15:0], byteMode_reg, byteSel_reg);
  assign highData  = byteMode_reg && byteSel_reg ? 16'h0000
                     : {8'h00, memRdata[23:16]};

  // extra cycles a remap access costs the instruction
  function automatic logic [1:0] extraCost(input psa_pkg::psa_req_s r);
    if (!r.inRepeat)
      extraCost = r.isMove ? psa_pkg::EXTRA_MOVE
                           : psa_pkg::EXTRA_OTHER;
    else if (r.repFirst || r.repLast || r.repIntExit || r.repIntEntry)
      extraCost = psa_pkg::EXTRA_OTHER;
    else
      extraCost = psa_pkg::EXTRA_NONE;
  endfunction

  always_comb begin
    state_next   = state_reg;
    memReq_next  = '0;
    coreRsp_next = '0;
    op_next      = op_reg;
    byteSel_next = byteSel_reg;
    byteMode_next = byteMode_reg;
    case (state_reg)
      ST_IDLE: begin
        if (reqLive && tableOp) begin
          // table ops own the array; remap cannot start meanwhile
          if (isWrite && tablePage_reg[psa_pkg::SPACE_BIT]) begin
            coreRsp_next.done    = 1'b1;
            coreRsp_next.refused = 1'b1;
          end else begin
            memReq_next.cfgSpace = tablePage_reg[psa_pkg::SPACE_BIT];
            memReq_next.addr     = tableAddr;
            memReq_next.rd       = !isWrite;
            memReq_next.wr       = isWrite;
            memReq_next.wrHigh   =
              coreReq.op == psa_pkg::OP_TABLE_WRITE_HIGH;
            memReq_next.wdata    = coreReq.wdata;
            op_next      = coreReq.op;
            byteSel_next = coreReq.effectiveAddr[0];
            byteMode_next = coreReq.byteMode;
            state_next   = isWrite ? ST_FETCH2 : ST_FETCH1;
          end
        end else if (reqLive && redirect) begin
          memReq_next.rd   = 1'b1;
          memReq_next.addr = remapAddr;
          op_next          = coreReq.op;
          state_next       = ST_FETCH1;
        end
      end
      ST_FETCH1: begin
        if (op_reg == psa_pkg::OP_DATA_READ) begin
          state_next = ST_FETCH2;
        end else begin
          coreRsp_next.done  = 1'b1;
          coreRsp_next.rdata =
            op_reg == psa_pkg::OP_TABLE_READ_HIGH ? highData : lowData;
          state_next = ST_IDLE;
        end
      end
      ST_FETCH2: begin
        coreRsp_next.done = 1'b1;
        if (op_reg == psa_pkg::OP_DATA_READ) begin
          coreRsp_next.rdata       = memRdata[15:0];
          coreRsp_next.redirected  = 1'b1;
          coreRsp_next.extraCycles = extraCost(coreReq);
        end
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state_reg       <= ST_IDLE;
      memReq_reg      <= '0;
      coreRsp_reg     <= '0;
      op_reg          <= psa_pkg::OP_NONE;
      byteSel_reg     <= 1'b0;
      byteMode_reg    <= 1'b0;
      busy_reg        <= 1'b0;
      tablePage_reg   <= psa_pkg::RST_PAGE;
      visPage_reg     <= psa_pkg::RST_PAGE;
      coreControl_reg <= psa_pkg::RST_CORE;
      awAddr_reg      <= 8'h00;
      awHeld_reg      <= 1'b0;
      wData_reg       <= 32'h00000000;
      wStrb_reg       <= 4'h0;
      wHeld_reg       <= 1'b0;
      bValid_reg      <= 1'b0;
      bResp_reg       <= psa_pkg::AXI_OKAY;
      rValid_reg      <= 1'b0;
      rData_reg       <= 32'h00000000;
      rResp_reg       <= psa_pkg::AXI_OKAY;
      refusedSticky_reg <= 1'b0;
    end else begin
      state_reg       <= state_next;
      memReq_reg      <= memReq_next;
      coreRsp_reg     <= coreRsp_next;
      op_reg          <= op_next;
      byteSel_reg     <= byteSel_next;
      byteMode_reg    <= byteMode_next;
      busy_reg        <= state_next != ST_IDLE;
      tablePage_reg   <= tablePage_next;
      visPage_reg     <= visPage_next;
      coreControl_reg <= coreControl_next;
      awAddr_reg      <= awAddr_next;
      awHeld_reg      <= awHeld_next;
      wData_reg       <= wData_next;
      wStrb_reg       <= wStrb_next;
      wHeld_reg       <= wHeld_next;
      bValid_reg      <= bValid_next;
      bResp_reg       <= bResp_next;
      rValid_reg      <= rValid_next;
      rData_reg       <= rData_next;
      rResp_reg       <= rResp_next;
      refusedSticky_reg <= refusedSticky_next;
    end
  end

  assign s_axi_awready = !awHeld_reg;
  assign s_axi_wready  = !wHeld_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_arready = !rValid_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;
  assign coreRsp       = coreRsp_reg;
  assign memReq        = memReq_reg;

  // ********************************************************************
  // checks
  // ********************************************************************
  sequence s_remapStart;
    state_reg == ST_IDLE && reqLive && redirect && !tableOp;
  endsequence

  property p_remapAddr;
    @(posedge clock) disable iff (!rstN)
    s_remapStart |=> memReq.rd && !memReq.addr[23] &&
      memReq.addr[22:15] == $past(visPage_reg);
  endproperty
  a_remapAddr: assert property (p_remapAddr)
    else $error("remap address wrong");

  property p_remapLate;
    @(posedge clock) disable iff (!rstN)
    s_remapStart |=> !coreRsp.done ##1 !coreRsp.done ##1 coreRsp.done;
  endproperty
  a_remapLate: assert property (p_remapLate)
    else $error("remap read timing wrong");

  property p_noCfgRemap;
    @(posedge clock) disable iff (!rstN)
    memReq.rd && !memReq.cfgSpace && state_reg == ST_FETCH1 &&
      op_reg == psa_pkg::OP_DATA_READ |-> !memReq.addr[23];
  endproperty
  a_noCfgRemap: assert property (p_noCfgRemap)
    else $error("remap reached bit 23");

  property p_tableAddr;
    @(posedge clock) disable iff (!rstN)
    state_reg == ST_IDLE && reqLive && tableOp && !isWrite |=>
      memReq.addr == {$past(tablePage_reg), $past(coreReq.effectiveAddr)};
  endproperty
  a_tableAddr: assert property (p_tableAddr)
    else $error("table address wrong");

  property p_cfgWriteRefused;
    @(posedge clock) disable iff (!rstN)
    state_reg == ST_IDLE && reqLive && isWrite &&
      tablePage_reg[7] |=> coreRsp.refused && !memReq.wr;
  endproperty
  a_cfgWriteRefused: assert property (p_cfgWriteRefused)
    else $error("config write not refused");

  property p_noRedirect;
    @(posedge clock) disable iff (!rstN)
    state_reg == ST_IDLE && coreReq.valid && !visEnable && !tableOp
      |=> !memReq.rd;
  endproperty
  a_noRedirect: assert property (p_noRedirect)
    else $error("redirect without enable");

  property p_phantom;
    @(posedge clock) disable iff (!rstN)
    state_reg == ST_FETCH1 && op_reg == psa_pkg::OP_TABLE_READ_HIGH
      |=> coreRsp.rdata[15:8] == 8'h00;
  endproperty
  a_phantom: assert property (p_phantom)
    else $error("phantom byte not zero");

  property p_moveCost;
    @(posedge clock) disable iff (!rstN)
    state_reg == ST_FETCH2 && op_reg == psa_pkg::OP_DATA_READ &&
      !coreReq.inRepeat && coreReq.isMove |=> coreRsp.extraCycles == 2'h1;
  endproperty
  a_moveCost: assert property (p_moveCost)
    else $error("move cost wrong");

endmodule // psa_access_unit

// File: psa_flash_model.sv
/*
 * psa_flash_model: behavioural program flash array for the bench.
 * assumes a one-cycle rd pulse on memReq; the word stands while rd is
 * high and for one cycle after it.
 */
`timescale 1ns/1ps
module psa_flash_model (
  // clock
  input  wire logic              clock,
  // request from the access unit
  input  wire psa_pkg::psa_mem_s memReq,
  // array data
  output logic [23:0]            memRdata
);
  // ******************************************************************
  // read port
  // ******************************************************************
  logic        holdReg = 1'b0;
  logic [23:0] wordReg = 24'h000000;

  function automatic logic [23:0] fetch(input logic [23:0] a);
    return {a[23:16] ^ a[7:0] ^ 8'hC3, a[15:0] ^ 16'h5A96};
  endfunction

  // outside the hold window the bus shows the inverse, so stale data
  // can never pass for a fresh fetch
  assign memRdata = memReq.rd ? fetch(memReq.addr)
                              : (holdReg ? wordReg : ~wordReg);
  always @(posedge clock) begin
    holdReg <= memReq.rd;
    if (memReq.rd) wordReg <= fetch(memReq.addr);
  end
endmodule // psa_flash_model

// File: tb_top.sv
/*
 * tb_top: self-checking bench for the program space access unit.
 * assumes the flash model answers reads and the core holds requests.
 */
`timescale 1ns/1ps
module tb_top;
  // ******************************************************************
  // signals
  // ******************************************************************
  logic clock = 1'b0, rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0,
        rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  psa_pkg::psa_req_s coreReq = '0;
  psa_pkg::psa_rsp_s coreRsp, gotRsp;
  psa_pkg::psa_mem_s memReq, rdSeen, wrSeen;
  logic [23:0] memRdata;
  int mismatches = 0, n_checks = 0, cycles = 0, rdCnt = 0, wrCnt = 0;
  integer seed = 32'h1735;

  psa_access_unit psa_access_unit_i (
    .clock(clock), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .coreReq(coreReq), .coreRsp(coreRsp),
    .memReq(memReq), .memRdata(memRdata));
  psa_flash_model psa_flash_model_i (
    .clock(clock), .memReq(memReq), .memRdata(memRdata));

  initial forever #10 clock = ~clock;

  // hang guard; a full run needs well under a tenth of this
  always @(posedge clock) begin
    cycles++;
    if (cycles > 40000) begin
      mismatches++;
      end_of_test();
    end
    if (memReq.rd === 1'b1) begin
      rdSeen <= memReq;
      rdCnt++;
    end
    if (memReq.wr === 1'b1) begin
      wrSeen <= memReq;
      wrCnt++;
    end
  end

  // ******************************************************************
  // tasks and expectations
  // ******************************************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    @(posedge clock);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    @(posedge clock);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // lat is -1 when no done comes within maxw cycles
  task automatic core_op(input psa_pkg::psa_op_e op, input logic bm,
                         input logic [15:0] ea, input logic [15:0] wd,
                         input logic [5:0] fl, input int maxw,
                         output int lat);
    lat = -1;
    @(posedge clock);
    coreReq <= {1'b1, op, bm, ea, wd, fl};
    for (int n = 1; n <= maxw; n++) begin
      @(posedge clock);
      if (coreRsp.done === 1'b1) begin
        gotRsp = coreRsp;
        lat = n - 1;
        break;
      end
    end
    // dropped at the edge that took done; the unit skips that edge
    coreReq.valid <= 1'b0;
    @(posedge clock);
  endtask

  function automatic logic [23:0] pword(logic [23:0] a);
    return {a[23:16] ^ a[7:0] ^ 8'hC3, a[15:0] ^ 16'h5A96};
  endfunction

  function automatic logic [15:0] exp_table(logic hi, logic bm, logic sel,
                                            logic [23:0] w);
    if (!hi) return bm ? {8'h00, sel ? w[15:8] : w[7:0]} : w[15:0];
    return (bm && sel) ? 16'h0000 : {8'h00, w[23:16]};
  endfunction

  function automatic logic [1:0] exp_extra(logic [5:0] f);
    if (!f[4]) return f[5] ? 2'h1 : 2'h2;
    return (f[3:0] != 4'h0) ? 2'h2 : 2'h0;
  endfunction

  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    int lat, cnt;
    logic [1:0] resp;
    logic [31:0] d;
    logic [7:0] pg;
    logic [15:0] ea, wd, mask;
    logic [5:0] fl;
    logic hi;
    static logic [5:0] corner[8] = '{6'h30, 6'h10, 6'h18, 6'h14, 6'h12, 6'h11,
                              6'h20, 6'h00};
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    axi_read(psa_pkg::OFF_TABLE_PAGE, d, resp);
    check("table page reset", d, 32'h0);
    axi_read(psa_pkg::OFF_CORE_CONTROL, d, resp);
    check("core control reset", d, 32'h0);
    axi_read(psa_pkg::OFF_STATUS, d, resp);
    check("status reset", d, 32'h0);
    axi_read(8'h10, d, resp);
    check("unmapped read resp", resp, psa_pkg::AXI_SLVERR);
    check("unmapped read data", d, 32'h0);
    axi_write(8'h20, 32'hFFFF, resp);
    check("unmapped write resp", resp, psa_pkg::AXI_SLVERR);
    $display("registers test done");
    for (int i = 0; i < 48; i++) begin
      pg = 8'($random(seed));
      ea = 16'($random(seed));
      hi = i[0];
      axi_write(psa_pkg::OFF_TABLE_PAGE, {24'h0, pg}, resp);
      check("page write resp", resp, psa_pkg::AXI_OKAY);
      axi_read(psa_pkg::OFF_TABLE_PAGE, d, resp);
      check("table page", d, {24'h0, pg});
      core_op(hi ? psa_pkg::OP_TABLE_READ_HIGH : psa_pkg::OP_TABLE_READ_LOW,
              i[1], ea, 16'h0, 6'h0, 8, lat);
      mask = (i[1] && !hi) ? 16'h00FF : 16'hFFFF;
      check("read addr", rdSeen.addr, {pg, ea});
      check("read space", rdSeen.cfgSpace, pg[7]);
      check("read latency", lat, 2);
      check("read data", gotRsp.rdata & mask,
            exp_table(hi, i[1], ea[0], pword({pg, ea})) & mask);
    end
    $display("table read test done");
    for (int i = 0; i < 16; i++) begin
      pg = 8'($random(seed));
      ea = 16'($random(seed));
      wd = 16'($random(seed));
      cnt = wrCnt;
      axi_write(psa_pkg::OFF_TABLE_PAGE, {24'h0, pg}, resp);
      core_op(i[0] ? psa_pkg::OP_TABLE_WRITE_HIGH
                   : psa_pkg::OP_TABLE_WRITE_LOW, 1'b0, ea, wd, 6'h0, 8, lat);
      check("write count", wrCnt - cnt, {31'h0, !pg[7]});
      check("write refused", gotRsp.refused, pg[7]);
      check("write latency", lat, pg[7] ? 1 : 2);
      if (!pg[7]) begin
        check("write addr", wrSeen.addr, {pg, ea});
        check("write high", wrSeen.wrHigh, i[0]);
        check("write data", wrSeen.wdata, wd);
      end else begin
        axi_read(psa_pkg::OFF_STATUS, d, resp);
        check("refused flag", d[1], 1'b1);
        axi_write(psa_pkg::OFF_STATUS, 32'h1, resp);
        axi_read(psa_pkg::OFF_STATUS, d, resp);
        check("refused clear", d[1], 1'b0);
      end
    end
    $display("table write test done");
    axi_write(psa_pkg::OFF_CORE_CONTROL, 32'h4, resp);
    axi_read(psa_pkg::OFF_STATUS, d, resp);
    check("enable status", d[0], 1'b1);
    for (int i = 0; i < 32; i++) begin
      pg = 8'($random(seed));
      ea = {1'b1, 15'($random(seed))};
      fl = (i < 8) ? corner[i] : 6'($random(seed));
      axi_write(psa_pkg::OFF_VIS_PAGE, {24'h0, pg}, resp);
      axi_read(psa_pkg::OFF_VIS_PAGE, d, resp);
      check("visibility page", d, {24'h0, pg});
      core_op(psa_pkg::OP_DATA_READ, 1'b0, ea, 16'h0, fl, 8, lat);
      check("remap addr", rdSeen.addr, {1'b0, pg, ea[14:0]});
      check("remap data", gotRsp.rdata,
            pword({1'b0, pg, ea[14:0]}) & 24'hFFFF);
      check("remap latency", lat, 3);
      check("redirected", gotRsp.redirected, 1'b1);
      check("extra cycles", gotRsp.extraCycles, exp_extra(fl));
    end
    $display("remap test done");
    for (int i = 0; i < 3; i++) begin
      axi_write(psa_pkg::OFF_CORE_CONTROL, (i == 0) ? 32'h4 : 32'h0, resp);
      cnt = rdCnt;
      ea = {(i == 1), 15'($random(seed))};
      core_op(psa_pkg::OP_DATA_READ, 1'b0, ea, 16'h0, 6'h0, 6, lat);
      check("no redirect done", lat, -1);
      check("no redirect fetch", rdCnt - cnt, 0);
    end
    $display("no redirect test done");
    end_of_test();
  end
endmodule // tb_top
